//--- rtl/pmc_option_ctrl.sv
// Option and channel control register bank with its two-wire serial slave.
`include "pmc_option_ctrl_regs.svh"

module pmc_option_ctrl
	import pmc_pkg::*;
#(
	parameter logic [6:0]  SLAVE_ADDR  = 7'h2A,
	parameter logic [23:0] UV5_WAIT_A  = 24'(`PMC_UV5_WAIT_A_CYC),
	parameter logic [23:0] UV5_WAIT_B  = 24'(`PMC_UV5_WAIT_B_CYC)
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        scl,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	input  wire pmc_fuse_t   fuse,
	input  wire logic        enPin,
	input  wire logic        ch3_ch4_on_pin,
	input  wire logic [6:0]  channel_sequencer_select,
	input  wire logic        ch5_auto_skip,
	input  wire logic        ch6_auto_skip,
	input  wire logic        sharedUvTrip,
	input  wire logic        ch5Undervolt,
	output pmc_option_t      optOut,
	output logic [6:0]       chanEnable,
	output logic             ch5UvTrip
);

	// The slave address value is arbitrary.
	pmc_bus_state_t state;
	logic       sclPrev;
	logic       sdaPrev;
	logic [3:0] bitCnt;
	logic [7:0] shift;
	logic [7:0] ptr;
	logic       rnw;
	logic       pullLow;
	logic       wrStb;
	logic [7:0] wrAddr;
	logic [7:0] wrData;
	logic       rdLoad;
	logic [7:0] rdAddr;
	logic [7:0] rdByte;
	logic [7:0] dcmGate;
	logic [7:0] ldoSel;
	logic [7:0] uv5Cfg;
	logic [7:0] optionCfg;
	logic [7:0] chanCtrl;
	logic       readSeen;
	logic       bothSkip;
	logic [23:0] uvCount;
	logic [23:0] uvLimit;
	logic        uvActive;

	wire sclRise   = scl & ~sclPrev;
	wire sclFall   = ~scl & sclPrev;
	wire startCond = scl & sclPrev & sdaPrev & ~sdaIn;
	wire stopCond  = scl & sclPrev & ~sdaPrev & sdaIn;

	assign bothSkip = ch5_auto_skip & ch6_auto_skip;

	always_ff @(posedge clk) begin : line_history
		if (sys_rst) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= scl;
			sdaPrev <= sdaIn;
		end
	end

	// Only the low level is ever driven, so the data output stays at zero.
	always_ff @(posedge clk) begin : pin_drive
		if (sys_rst) begin
			sdaOut <= 1'b0;
			sdaOeN <= 1'b1;
		end else begin
			sdaOut <= 1'b0;
			sdaOeN <= ~pullLow;
		end
	end

	always_ff @(posedge clk) begin : bus_fsm
		if (sys_rst) begin
			state   <= PMC_IDLE;
			bitCnt  <= 4'h0;
			shift   <= 8'h00;
			ptr     <= 8'h00;
			rnw     <= 1'b0;
			pullLow <= 1'b0;
			wrStb   <= 1'b0;
			wrAddr  <= 8'h00;
			wrData  <= 8'h00;
			rdLoad  <= 1'b0;
			rdAddr  <= 8'h00;
		end else begin
			wrStb  <= 1'b0;
			rdLoad <= 1'b0;
			if (stopCond) begin
				state   <= PMC_IDLE;
				pullLow <= 1'b0;
			end else if (startCond) begin
				state   <= PMC_ADDR;
				bitCnt  <= 4'h0;
				pullLow <= 1'b0;
			end else begin
				unique case (state)
					PMC_IDLE: begin
						pullLow <= 1'b0;
					end
					PMC_ADDR, PMC_REG, PMC_WDAT: begin
						if (sclRise) begin
							shift  <= {shift[6:0], sdaIn};
							bitCnt <= bitCnt + 4'h1;
						end else if (sclFall && bitCnt == 4'h8) begin
							bitCnt <= 4'h0;
							if (state == PMC_ADDR) begin
								if (shift[7:1] == SLAVE_ADDR) begin
									rnw     <= shift[0];
									pullLow <= 1'b1;
									state   <= PMC_ACKA;
								end else begin
									state <= PMC_IDLE;
								end
							end else if (state == PMC_REG) begin
								ptr     <= shift;
								pullLow <= 1'b1;
								state   <= PMC_ACKD;
							end else begin
								wrStb   <= 1'b1;
								wrAddr  <= ptr;
								wrData  <= shift;
								ptr     <= ptr + 8'h01;
								pullLow <= 1'b1;
								state   <= PMC_ACKD;
							end
						end
					end
					PMC_ACKA: begin
						if (sclFall) begin
							if (rnw) begin
								shift   <= rdByte;
								pullLow <= ~rdByte[7];
								rdLoad  <= 1'b1;
								rdAddr  <= ptr;
								ptr     <= ptr + 8'h01;
								state   <= PMC_RDAT;
							end else begin
								pullLow <= 1'b0;
								state   <= PMC_REG;
							end
						end
					end
					PMC_ACKD: begin
						if (sclFall) begin
							pullLow <= 1'b0;
							state   <= PMC_WDAT;
						end
					end
					PMC_RDAT: begin
						if (sclRise) begin
							bitCnt <= bitCnt + 4'h1;
						end else if (sclFall) begin
							if (bitCnt == 4'h8) begin
								bitCnt  <= 4'h0;
								pullLow <= 1'b0;
								state   <= PMC_RACK;
							end else begin
								shift   <= {shift[6:0], 1'b0};
								pullLow <= ~shift[6];
							end
						end
					end
					PMC_RACK: begin
						if (sclRise && sdaIn) begin
							state <= PMC_IDLE;
						end else if (sclFall) begin
							shift   <= rdByte;
							pullLow <= ~rdByte[7];
							rdLoad  <= 1'b1;
							rdAddr  <= ptr;
							ptr     <= ptr + 8'h01;
							state   <= PMC_RDAT;
						end
					end
				endcase
			end
		end
	end

	// Reserved bits are never stored, so they read back as zero.
	always_comb begin
		unique case (ptr)
			`PMC_OFS_DCM_GATE: rdByte = dcmGate;
			`PMC_OFS_LDO_SEL:  rdByte = ldoSel;
			`PMC_OFS_UV5:      rdByte = uv5Cfg;
			`PMC_OFS_OPTION:   rdByte = optionCfg;
			`PMC_OFS_CHAN:     rdByte = {readSeen, chanCtrl[6:0]};
			default:           rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin : option_regs
		if (sys_rst) begin
			dcmGate   <= fuse.dcmGate & `PMC_MASK_DCM_GATE;
			ldoSel    <= fuse.ldoSel & `PMC_MASK_LDO_SEL;
			uv5Cfg    <= fuse.uv5 & `PMC_MASK_UV5;
			optionCfg <= fuse.option & `PMC_MASK_OPTION;
		end else begin
			if (wrStb) begin
				unique case (wrAddr)
					`PMC_OFS_DCM_GATE: dcmGate <= wrData & `PMC_MASK_DCM_GATE;
					`PMC_OFS_LDO_SEL:  ldoSel <= wrData & `PMC_MASK_LDO_SEL;
					`PMC_OFS_UV5:      uv5Cfg <= wrData & `PMC_MASK_UV5;
					`PMC_OFS_OPTION:   optionCfg <= wrData & `PMC_MASK_OPTION;
					default: begin
					end
				endcase
			end
			// A discontinuous request without both auto-skip modes is dropped.
			if (!bothSkip) begin
				dcmGate[`PMC_BIT_DCM] <= 1'b0;
			end
		end
	end

	// Writing while the master pin is low has no effect, since the register is held clear.
	always_ff @(posedge clk) begin : channel_reg
		if (sys_rst || !enPin) begin
			chanCtrl <= `PMC_RST_CHAN;
		end else if (wrStb && wrAddr == `PMC_OFS_CHAN) begin
			chanCtrl <= wrData & `PMC_MASK_CHAN;
		end
	end

	always_ff @(posedge clk) begin : read_valid
		if (sys_rst || !enPin) begin
			readSeen <= 1'b0;
		end else if (rdLoad && rdAddr == `PMC_OFS_CHAN) begin
			readSeen <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin : channel_out
		if (sys_rst) begin
			chanEnable <= 7'h00;
		end else begin
			for (int i = 0; i < 7; i++) begin
				chanEnable[i] <= enPin & ~channel_sequencer_select[i] & chanCtrl[i];
			end
			if (!optionCfg[`PMC_BIT_GATE_CH3]) begin
				chanEnable[`PMC_IDX_CH3] <= enPin & ~channel_sequencer_select[`PMC_IDX_CH3]
					& ch3_ch4_on_pin;
			end
			if (!optionCfg[`PMC_BIT_GATE_CH4]) begin
				chanEnable[`PMC_IDX_CH4] <= enPin & ~channel_sequencer_select[`PMC_IDX_CH4]
					& ch3_ch4_on_pin;
			end
		end
	end

	always_ff @(posedge clk) begin : option_out
		if (sys_rst) begin
			optOut <= '0;
		end else begin
			optOut.auto_discontinuous_ch56 <= dcmGate[`PMC_BIT_DCM] & bothSkip;
			optOut.ch1_half_gate           <= dcmGate[`PMC_BIT_HALF_GATE];
			optOut.keepalive2_input_sel    <= ldoSel[`PMC_BIT_KA2_SEL];
			optOut.keepalive1_input_sel    <= ldoSel[`PMC_BIT_KA1_SEL];
			optOut.ch1_low_range           <= optionCfg[`PMC_BIT_LOW_RANGE];
			optOut.off_delay_x4            <= optionCfg[`PMC_BIT_OFF_X4];
		end
	end

	// The standalone wait is counted here because the shared path has its own timer elsewhere.
	wire [1:0] uvCode = uv5Cfg[`PMC_UV5_WAIT_HI:`PMC_UV5_WAIT_LO];
	assign uvActive = uv5Cfg[`PMC_BIT_UV5_SA] & (uvCode != `PMC_UV5_CODE_OFF);

	always_comb begin
		unique case (uvCode)
			`PMC_UV5_CODE_21MS: uvLimit = UV5_WAIT_A;
			`PMC_UV5_CODE_45MS: uvLimit = UV5_WAIT_B;
			default:            uvLimit = 24'h000000;
		endcase
	end

	always_ff @(posedge clk) begin : uv5_timer
		if (sys_rst || !(uvActive && ch5Undervolt)) begin
			uvCount <= 24'h000000;
		end else if (uvCount < uvLimit) begin
			uvCount <= uvCount + 24'h000001;
		end
	end

	always_ff @(posedge clk) begin : uv5_trip
		if (sys_rst) begin
			ch5UvTrip <= 1'b0;
		end else if (!uv5Cfg[`PMC_BIT_UV5_SA]) begin
			ch5UvTrip <= sharedUvTrip;
		end else begin
			ch5UvTrip <= uvActive & ch5Undervolt & (uvCount >= uvLimit);
		end
	end

	a_dcm_needs_skip: assert property (@(posedge clk) disable iff (sys_rst)
		!bothSkip |=> !dcmGate[`PMC_BIT_DCM] && !optOut.auto_discontinuous_ch56)
		else $error("Discontinuous bit held without both auto-skip bits.");

	a_fuse_load_reset: assert property (@(posedge clk)
		sys_rst |=> optionCfg == ($past(fuse.option) & `PMC_MASK_OPTION)
			&& ldoSel == ($past(fuse.ldoSel) & `PMC_MASK_LDO_SEL))
		else $error("Option registers did not load the fuse values.");

	a_pin_low_clears: assert property (@(posedge clk) disable iff (sys_rst)
		!enPin |=> chanCtrl == `PMC_RST_CHAN && chanEnable == 7'h00)
		else $error("Channels not cleared with the master pin low.");

	a_sequencer_ignores: assert property (@(posedge clk) disable iff (sys_rst)
		channel_sequencer_select[0] |=> !chanEnable[0])
		else $error("Sequencer-mode channel followed its on bit.");

	a_pin_gates_ch3: assert property (@(posedge clk) disable iff (sys_rst)
		(enPin && !optionCfg[`PMC_BIT_GATE_CH3] && !channel_sequencer_select[`PMC_IDX_CH3])
		|=> chanEnable[`PMC_IDX_CH3] == $past(ch3_ch4_on_pin))
		else $error("Channel 3 did not follow the shared on pin.");

	a_first_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(rdLoad && rdAddr == `PMC_OFS_CHAN && !readSeen) |-> !shift[`PMC_BIT_READ_VALID]
			##1 (readSeen || !$past(enPin)))
		else $error("Valid flag wrong around the first channel read.");

	a_half_gate_follows: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(dcmGate[`PMC_BIT_HALF_GATE]) |=> optOut.ch1_half_gate == $past(dcmGate[0]))
		else $error("Half gate output did not follow its bit.");

	a_uv5_shared_path: assert property (@(posedge clk) disable iff (sys_rst)
		!uv5Cfg[`PMC_BIT_UV5_SA] |=> ch5UvTrip == $past(sharedUvTrip))
		else $error("Channel 5 trip not following shared protection.");

	a_uv5_code_off: assert property (@(posedge clk) disable iff (sys_rst)
		(uv5Cfg[`PMC_BIT_UV5_SA] && uvCode == `PMC_UV5_CODE_OFF) [*2] |-> !ch5UvTrip)
		else $error("Standalone protection tripped while disabled.");

	a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(optionCfg & ~`PMC_MASK_OPTION) == 8'h00 && (uv5Cfg & ~`PMC_MASK_UV5) == 8'h00)
		else $error("Reserved bits stored a written value.");

endmodule : pmc_option_ctrl

//--- rtl/pmc_option_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the option bank.
`ifndef PMC_OPTION_CTRL_REGS_SVH
`define PMC_OPTION_CTRL_REGS_SVH

`define PMC_OFS_DCM_GATE    8'h20
`define PMC_OFS_LDO_SEL     8'h21
`define PMC_OFS_UV5         8'h22
`define PMC_OFS_OPTION      8'h23
`define PMC_OFS_CHAN        8'h30

`define PMC_BIT_DCM         4
`define PMC_BIT_HALF_GATE   0
`define PMC_BIT_KA2_SEL     4
`define PMC_BIT_KA1_SEL     0
`define PMC_BIT_UV5_SA      0
`define PMC_UV5_WAIT_HI     5
`define PMC_UV5_WAIT_LO     4
`define PMC_BIT_LOW_RANGE   3
`define PMC_BIT_OFF_X4      2
`define PMC_BIT_GATE_CH4    1
`define PMC_BIT_GATE_CH3    0
`define PMC_BIT_READ_VALID  7
`define PMC_IDX_CH3         2
`define PMC_IDX_CH4         3

`define PMC_MASK_DCM_GATE   8'h11
`define PMC_MASK_LDO_SEL    8'h11
`define PMC_MASK_UV5        8'h31
`define PMC_MASK_OPTION     8'h0F
`define PMC_MASK_CHAN       8'h7F
`define PMC_RST_CHAN        8'h00

`define PMC_UV5_CODE_0MS    2'h0
`define PMC_UV5_CODE_21MS   2'h1
`define PMC_UV5_CODE_45MS   2'h2
`define PMC_UV5_CODE_OFF    2'h3

`define PMC_CLK_MHZ         250
`define PMC_UV5_WAIT_A_MS   21
`define PMC_UV5_WAIT_B_MS   45
`define PMC_UV5_WAIT_A_CYC  (`PMC_UV5_WAIT_A_MS * 1000 * `PMC_CLK_MHZ)
`define PMC_UV5_WAIT_B_CYC  (`PMC_UV5_WAIT_B_MS * 1000 * `PMC_CLK_MHZ)

`endif

//--- rtl/pmc_pkg.sv
// Types shared by the option and channel control bank.
package pmc_pkg;

	typedef struct packed {
		logic [7:0] dcmGate;
		logic [7:0] ldoSel;
		logic [7:0] uv5;
		logic [7:0] option;
	} pmc_fuse_t;

	typedef struct packed {
		logic auto_discontinuous_ch56;
		logic ch1_half_gate;
		logic keepalive2_input_sel;
		logic keepalive1_input_sel;
		logic ch1_low_range;
		logic off_delay_x4;
	} pmc_option_t;

	typedef enum logic [3:0] {
		PMC_IDLE,
		PMC_ADDR,
		PMC_REG,
		PMC_WDAT,
		PMC_ACKA,
		PMC_ACKD,
		PMC_RDAT,
		PMC_RACK
	} pmc_bus_state_t;

endpackage : pmc_pkg

//--- test/pmc_host_model.sv
// Behavioural two-wire bus host that reaches the option bank's registers.
module pmc_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaRel
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 8;
	logic nack;
	initial begin
		scl <= 1'b1;
		sdaRel <= 1'b1;
		nack <= 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic put_bit(input logic b, output logic r);
		sdaRel <= b;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		r = sdaWire;
		scl <= 1'b0;
		tick(HALF / 2);
	endtask : put_bit
	task automatic put_byte(input logic [7:0] d, input logic ackOut, output logic [7:0] r,
			output logic a);
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], r[i]);
		end
		put_bit(ackOut, a);
	endtask : put_byte
	// Data is released before scl rises so a repeated start never looks like a stop.
	task automatic start_cond();
		sdaRel <= 1'b1;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		sdaRel <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b0;
		tick(HALF / 2);
	endtask : start_cond
	task automatic stop_cond();
		sdaRel <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		sdaRel <= 1'b1;
		tick(HALF);
	endtask : stop_cond
	task automatic address(input logic [7:0] regAddr);
		logic [7:0] r;
		logic       a;
		start_cond();
		put_byte({DEV_ADDR, 1'b0}, 1'b1, r, a);
		nack |= a;
		put_byte(regAddr, 1'b1, r, a);
		nack |= a;
	endtask : address
	task automatic write_reg(input logic [7:0] regAddr, input logic [7:0] d);
		logic [7:0] r;
		logic       a;
		address(regAddr);
		put_byte(d, 1'b1, r, a);
		nack |= a;
		stop_cond();
	endtask : write_reg
	task automatic read_reg(input logic [7:0] regAddr, output logic [7:0] d);
		logic [7:0] r;
		logic       a;
		address(regAddr);
		start_cond();
		put_byte({DEV_ADDR, 1'b1}, 1'b1, r, a);
		nack |= a;
		put_byte(8'hFF, 1'b1, d, a);
		stop_cond();
	endtask : read_reg
	// The channel bits are trusted only once the valid flag reads 1.
	task automatic read_valid(input logic [7:0] regAddr, output logic [7:0] d);
		d = 8'h00;
		for (int i = 0; i < 8 && d[7] !== 1'b1; i++) begin
			read_reg(regAddr, d);
		end
	endtask : read_valid
endmodule : pmc_host_model

//--- test/pmc_option_ctrl_tb.sv
// Self-checking bench for the option and channel control bank.
module pmc_option_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WA = 20;
	localparam int WB = 45;
	logic               clk = 1'b0;
	logic               sysRst, scl, sdaRel, sdaOut, sdaOeN, sdaWire;
	pmc_pkg::pmc_fuse_t fuse;
	pmc_pkg::pmc_option_t optOut;
	logic               enPin, pinCh34, skip5, skip6, sharedUv, uv5, uvTrip;
	logic [6:0]         seqSel, chanEn;
	logic [7:0]         d;
	int                 miscompares = 0;
	int                 nCompared = 0;
	logic [7:0] offs [4] = '{8'h20, 8'h21, 8'h22, 8'h23};
	logic [7:0] masks [4] = '{8'h11, 8'h11, 8'h31, 8'h0F};
	logic [7:0] vals [2] = '{8'hFF, 8'h00};
	logic [7:0] codes [4] = '{8'h01, 8'h11, 8'h21, 8'h31};
	int         waits [4] = '{0, WA, WB, 100};
	logic [7:0] late [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
	logic [7:0] fuseB [4] = '{8'h01, 8'h10, 8'h21, 8'h0A};
	// The data line has a pull-up, so a released line reads high.
	assign sdaWire = sdaRel & (sdaOeN | sdaOut);
	always #2 clk = ~clk;
	pmc_option_ctrl #(.UV5_WAIT_A(24'(WA)), .UV5_WAIT_B(24'(WB))) pmc_option_ctrl_inst (
		.clk(clk), .sys_rst(sysRst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOeN(sdaOeN), .fuse(fuse), .enPin(enPin), .ch3_ch4_on_pin(pinCh34),
		.channel_sequencer_select(seqSel), .ch5_auto_skip(skip5), .ch6_auto_skip(skip6),
		.sharedUvTrip(sharedUv), .ch5Undervolt(uv5), .optOut(optOut), .chanEnable(chanEn),
		.ch5UvTrip(uvTrip));
	pmc_host_model pmc_host_model_inst (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaRel(sdaRel));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		pmc_host_model_inst.read_reg(a, r);
		check(r, exp);
	endtask : rd_chk
	task automatic giveVerdict();
		$display("compared %0d mismatched %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : giveVerdict
	initial begin
		tick(80000);
		miscompares++;
		giveVerdict();
	end
	initial begin
		sysRst <= 1'b1;
		fuse <= '1;
		{enPin, pinCh34, sharedUv, uv5} <= 4'h0;
		{skip5, skip6} <= 2'h3;
		seqSel <= 7'h00;
		tick(5);
		sysRst <= 1'b0;
		tick(4);
		for (int i = 0; i < 4; i++) begin
			rd_chk(offs[i], masks[i]);
		end
		check({2'h0, optOut}, 8'h3F);
		$display("done: fuse defaults");
		for (int v = 0; v < 2; v++) begin
			for (int i = 0; i < 4; i++) begin
				pmc_host_model_inst.write_reg(offs[i], vals[v]);
				rd_chk(offs[i], vals[v] & masks[i]);
			end
			check({2'h0, optOut}, vals[v] & 8'h3F);
		end
		skip6 <= 1'b0;
		pmc_host_model_inst.write_reg(8'h20, 8'h11);
		rd_chk(8'h20, 8'h01);
		skip6 <= 1'b1;
		pmc_host_model_inst.write_reg(8'h25, 8'hFF);
		rd_chk(8'h25, 8'h00);
		check({7'h0, pmc_host_model_inst.nack}, 8'h00);
		$display("done: register access");
		sharedUv <= 1'b1;
		tick(3);
		check({7'h0, uvTrip}, 8'h01);
		sharedUv <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			pmc_host_model_inst.write_reg(8'h22, codes[i]);
			uv5 <= 1'b1;
			if (waits[i] > 5) begin
				tick(waits[i] - 5);
				check({7'h0, uvTrip}, 8'h00);
				tick(10);
			end else begin
				tick(3);
			end
			check({7'h0, uvTrip}, late[i]);
			uv5 <= 1'b0;
			tick(3);
		end
		$display("done: undervoltage");
		enPin <= 1'b1;
		tick(2);
		pmc_host_model_inst.write_reg(8'h23, 8'h03);
		pmc_host_model_inst.write_reg(8'h30, 8'h7F);
		rd_chk(8'h30, 8'h7F);
		pmc_host_model_inst.read_valid(8'h30, d);
		check(d, 8'hFF);
		check({1'b0, chanEn}, 8'h7F);
		seqSel <= 7'h55;
		tick(2);
		check({1'b0, chanEn}, 8'h2A);
		seqSel <= 7'h00;
		pmc_host_model_inst.write_reg(8'h23, 8'h00);
		tick(2);
		check({1'b0, chanEn}, 8'h73);
		pinCh34 <= 1'b1;
		enPin <= 1'b0;
		tick(2);
		check({1'b0, chanEn}, 8'h00);
		rd_chk(8'h30, 8'h00);
		enPin <= 1'b1;
		tick(2);
		rd_chk(8'h30, 8'h00);
		check({1'b0, chanEn}, 8'h0C);
		$display("done: channel control");
		// A second fuse pattern shows the option registers load the fuses, not constants.
		pmc_host_model_inst.write_reg(8'h30, 8'h7F);
		sysRst <= 1'b1;
		fuse <= 32'h0110_21FA;
		tick(5);
		sysRst <= 1'b0;
		tick(4);
		for (int i = 0; i < 4; i++) begin
			rd_chk(offs[i], fuseB[i]);
		end
		rd_chk(8'h30, 8'h00);
		check({2'h0, optOut}, 8'h1A);
		check({1'b0, chanEn}, 8'h04);
		$display("done: mid-run reset");
		giveVerdict();
	end
endmodule : pmc_option_ctrl_tb
